// [include/itp_pkg.sv]
// constants and carrier types of the ingress tag parser and filter
package itp_pkg;
	// ==========================================================
	// tag identifiers
	localparam logic [15:0] TPID_CTAG   = 16'h8100;
	localparam logic [15:0] TPID_STAG   = 16'h88a8;
	localparam logic [15:0] TPID_EXT    = 16'h893f;
	localparam logic [15:0] TPID_RED    = 16'hf1c1;
	localparam int          NUM_CUSTOM  = 3;
	localparam int          MAX_VLAN    = 3;
	localparam int          NUM_HW      = 16;
	localparam int          NUM_TYPES   = 5;
	// halfwords taken by each tag kind
	localparam int          HW_VLAN     = 2;
	localparam int          HW_RED      = 3;
	localparam int          HW_EXT      = 4;
	localparam logic [39:0] CTRL_PREFIX = 40'h0180c20000;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0]  ADR_CTRL    = 8'h00;
	localparam logic [7:0]  ADR_CUSTOM0 = 8'h04;
	localparam logic [7:0]  ADR_CUSTOM1 = 8'h08;
	localparam logic [7:0]  ADR_CUSTOM2 = 8'h0c;
	localparam logic [7:0]  ADR_VALID   = 8'h10;
	localparam logic [7:0]  ADR_FILT    = 8'h14;
	localparam logic [7:0]  ADR_STAT    = 8'h18;
	// field positions
	localparam int          CTRL_EXT_EN    = 0;
	localparam int          CTRL_RED_EN    = 1;
	localparam int          CTRL_DROP_MC   = 2;
	localparam int          CTRL_DROP_NULL = 3;
	localparam int          VALID_ROUTE_LSB = 16;
	localparam int          FILT_EXT_LSB   = 8;
	// reset values
	localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
	localparam logic [15:0] RST_CUSTOM  = 16'h0000;
	localparam logic [31:0] RST_VALID   = 32'h0000_0000;
	localparam logic [31:0] RST_FILT    = 32'h0000_0000;
	// acceptance filter settings
	localparam logic [1:0]  FLT_ALL     = 2'h0;
	localparam logic [1:0]  FLT_WITHOUT = 2'h1;
	localparam logic [1:0]  FLT_WITH    = 2'h2;
	// pipe actions
	localparam logic [1:0]  ACT_NONE     = 2'h0;
	localparam logic [1:0]  ACT_INJECT   = 2'h1;
	localparam logic [1:0]  ACT_EXTRACT  = 2'h2;
	localparam logic [1:0]  ACT_LOOPBACK = 2'h3;
	// pipe points, analyzer side in flow order, then the rewriter side
	localparam logic [3:0]  PT_NONE             = 4'h0;
	localparam logic [3:0]  PT_CLASSIFIER       = 4'h1;
	localparam logic [3:0]  PT_LOOKUP           = 4'h2;
	localparam logic [3:0]  PT_PORT_MAINT       = 4'h3;
	localparam logic [3:0]  PT_OUTER_MAINT      = 4'h4;
	localparam logic [3:0]  PT_OUTER_SW         = 4'h5;
	localparam logic [3:0]  PT_INNER_MAINT      = 4'h6;
	localparam logic [3:0]  PT_INNER_SW         = 4'h7;
	localparam logic [3:0]  PT_RW_SATELLITE     = 4'h8;
	localparam logic [3:0]  PT_RW_PORT_MAINT    = 4'h9;
	localparam logic [3:0]  PT_RW_OUTER_MAINT   = 4'ha;
	localparam logic [3:0]  PT_RW_OUTER_SW      = 4'hb;
	localparam logic [3:0]  PT_RW_INNER_MAINT   = 4'hc;
	localparam logic [3:0]  PT_RW_INNER_SW      = 4'hd;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic [47:0]             dmac;
		logic [47:0]             smac;
		logic [1:0]              pipe_action;
		logic [3:0]              pipe_point;
		logic [NUM_HW-1:0][15:0] hw;
	} itp_frame_t;
	typedef struct packed {
		logic                    active;
		logic                    non_ip;
		logic                    tag_info_available;
		logic                    ext_present;
		logic                    red_present;
		logic [47:0]             ext_tag;
		logic [15:0]             red_sequence_number;
		logic [1:0]              vlan_count;
		logic [2:0][15:0]        vlan_tci;
		logic [2:0][2:0]         vlan_type;
		logic [15:0]             ethertype;
		logic                    routable;
		logic                    discard;
		logic                    learn_dis;
		logic [3:0]              pipe_point;
	} itp_result_t;
endpackage : itp_pkg

// [design/itp_parser_filter.sv]
// ingress tag parser, pipe point evaluation, routing check and acceptance filter
`timescale 1ns/10ps
`default_nettype none
module itp_parser_filter import itp_pkg::*; (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// register bus
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [7:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_w,
	output logic [31:0]      wb_dat_r,
	output logic             wb_ack,
	// frame headers in
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire itp_frame_t  in_frame,
	// classification out
	output logic             out_valid,
	input  wire logic        out_ready,
	output itp_result_t      out_res
);
	// ==========================================================
	// registers
	logic [31:0]                 ctrl;
	logic [NUM_CUSTOM-1:0][15:0] custom_service_tpid_cfg;
	logic [31:0]                 tag_id_validity_ctrl;
	logic [31:0]                 filt;
	logic [15:0]                 cnt_accept;
	logic [15:0]                 cnt_discard;

	wire logic        ext_tag_parse_en = ctrl[CTRL_EXT_EN];
	wire logic        red_tag_parse_en = ctrl[CTRL_RED_EN];
	wire logic [14:0] tag_id_invalid_mask = tag_id_validity_ctrl[14:0];
	wire logic [3:0]  route_tag_count_mask = tag_id_validity_ctrl[VALID_ROUTE_LSB +: 4];
	wire logic [5:0]  vlan_accept_filter_cfg = filt[5:0];
	wire logic [1:0]  ext_tag_accept_filter_cfg = filt[FILT_EXT_LSB +: 2];

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	wire logic        bus_req  = wb_cyc && wb_stb && !wb_ack;
	wire logic        bus_wr   = bus_req && wb_we;
	wire logic        hit_ctrl = wb_adr == ADR_CTRL;
	wire logic        hit_c0   = wb_adr == ADR_CUSTOM0;
	wire logic        hit_c1   = wb_adr == ADR_CUSTOM1;
	wire logic        hit_c2   = wb_adr == ADR_CUSTOM2;
	wire logic        hit_val  = wb_adr == ADR_VALID;
	wire logic        hit_filt = wb_adr == ADR_FILT;
	wire logic        hit_stat = wb_adr == ADR_STAT;
	wire logic [31:0] rd_mux   = hit_ctrl ? ctrl :
		hit_c0   ? {16'h0000, custom_service_tpid_cfg[0]} :
		hit_c1   ? {16'h0000, custom_service_tpid_cfg[1]} :
		hit_c2   ? {16'h0000, custom_service_tpid_cfg[2]} :
		hit_val  ? tag_id_validity_ctrl :
		hit_filt ? filt :
		hit_stat ? {cnt_discard, cnt_accept} : 32'h0000_0000;
	wire logic [31:0] wr_c0 = merge({16'h0000, custom_service_tpid_cfg[0]}, wb_dat_w, wb_sel);
	wire logic [31:0] wr_c1 = merge({16'h0000, custom_service_tpid_cfg[1]}, wb_dat_w, wb_sel);
	wire logic [31:0] wr_c2 = merge({16'h0000, custom_service_tpid_cfg[2]}, wb_dat_w, wb_sel);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wb_ack   <= 1'b0;
			wb_dat_r <= 32'h0000_0000;
		end else begin
			wb_ack   <= bus_req;
			wb_dat_r <= bus_req ? rd_mux : wb_dat_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl                    <= RST_CTRL;
			custom_service_tpid_cfg <= {NUM_CUSTOM{RST_CUSTOM}};
			tag_id_validity_ctrl    <= RST_VALID;
			filt                    <= RST_FILT;
		end else if (bus_wr) begin
			if (hit_ctrl) ctrl <= merge(ctrl, wb_dat_w, wb_sel) & 32'h0000_000f;
			if (hit_c0) custom_service_tpid_cfg[0] <= wr_c0[15:0];
			if (hit_c1) custom_service_tpid_cfg[1] <= wr_c1[15:0];
			if (hit_c2) custom_service_tpid_cfg[2] <= wr_c2[15:0];
			if (hit_val) tag_id_validity_ctrl <= merge(tag_id_validity_ctrl, wb_dat_w, wb_sel) & 32'h000f_7fff;
			if (hit_filt) filt <= merge(filt, wb_dat_w, wb_sel) & 32'h0000_033f;
		end
	end

	// ==========================================================
	// tag walk
	function automatic logic [2:0] vlan_kind(input logic [15:0] t,
		input logic [NUM_CUSTOM-1:0][15:0] cust, output logic hit);
		logic [2:0] k;
		k   = 3'h0;
		hit = 1'b0;
		if (t == TPID_CTAG) begin
			hit = 1'b1;
			k   = 3'h0;
		end else if (t == TPID_STAG) begin
			hit = 1'b1;
			k   = 3'h1;
		end else begin
			for (int c = 0; c < NUM_CUSTOM; c++) begin
				if (!hit && t == cust[c]) begin
					hit = 1'b1;
					k   = 3'(c + 2);
				end
			end
		end
		return k;
	endfunction : vlan_kind

	itp_result_t p;
	always_comb begin
		int     pos;
		int     ntag;
		logic   stop;
		logic   is_v;
		logic [2:0]  kind;
		logic [15:0] t;
		pos  = 0;
		ntag = 0;
		stop = 1'b0;
		is_v = 1'b0;
		kind = 3'h0;
		t    = 16'h0000;
		p    = '0;
		if (ext_tag_parse_en && in_frame.hw[0] == TPID_EXT) begin
			p.ext_present = 1'b1;
			p.ext_tag     = {in_frame.hw[1], in_frame.hw[2], in_frame.hw[3]};
			pos           = HW_EXT;
		end
		// without the enable 0x893f is unknown and stops the walk here
		for (int k = 0; k <= MAX_VLAN; k++) begin
			if (!stop) begin
				t    = in_frame.hw[pos];
				kind = vlan_kind(t, custom_service_tpid_cfg, is_v);
				if (is_v) begin
					if (ntag >= MAX_VLAN) begin
						p.non_ip = 1'b1;
						stop     = 1'b1;
					end else begin
						p.vlan_tci[p.vlan_count]  = in_frame.hw[pos+1];
						p.vlan_type[p.vlan_count] = kind;
						p.vlan_count = p.vlan_count + 2'h1;
						ntag = ntag + 1;
						pos  = pos + HW_VLAN;
					end
				end else if (red_tag_parse_en && t == TPID_RED) begin
					if (p.red_present || ntag >= MAX_VLAN) begin
						p.non_ip = 1'b1;
						stop     = 1'b1;
					end else begin
						p.red_present         = 1'b1;
						p.red_sequence_number = in_frame.hw[pos+2];
						ntag = ntag + 1;
						pos  = pos + HW_RED;
					end
				end else if (ext_tag_parse_en && t == TPID_EXT && p.ext_present) begin
					// a second extension tag after the first, directly or behind vlan or redundancy tags, marks the frame non-ip
					p.non_ip = 1'b1;
					stop     = 1'b1;
				end else begin
					stop = 1'b1;
				end
			end
		end
		p.ethertype          = in_frame.hw[pos];
		p.tag_info_available = p.ext_present || p.red_present;
	end

	// ==========================================================
	// pipe point evaluation
	logic [3:0] pt_in;
	always_comb begin
		pt_in = in_frame.pipe_point;
		if (in_frame.pipe_action == ACT_LOOPBACK) begin
			unique case (in_frame.pipe_point)
				PT_RW_PORT_MAINT:  pt_in = PT_PORT_MAINT;
				PT_RW_OUTER_MAINT: pt_in = PT_OUTER_MAINT;
				PT_RW_INNER_MAINT: pt_in = PT_INNER_MAINT;
				PT_RW_SATELLITE:   pt_in = PT_LOOKUP;
				PT_RW_OUTER_SW:    pt_in = PT_OUTER_SW;
				PT_RW_INNER_SW:    pt_in = PT_INNER_SW;
				default:           pt_in = in_frame.pipe_point;
			endcase
		end
	end
	wire logic act_none = in_frame.pipe_action == ACT_NONE;
	wire logic act_inj  = in_frame.pipe_action == ACT_INJECT && pt_in <= PT_CLASSIFIER;
	wire logic act_ext  = in_frame.pipe_action == ACT_EXTRACT && pt_in >= PT_CLASSIFIER;
	wire logic act_loop = in_frame.pipe_action == ACT_LOOPBACK && pt_in <= PT_CLASSIFIER;
	wire logic active   = act_none || act_inj || act_ext || act_loop;

	// ==========================================================
	// routing check and acceptance filters
	logic       tags_valid;
	logic       vlan_reject;
	always_comb begin
		tags_valid  = 1'b1;
		vlan_reject = 1'b0;
		for (int i = 0; i < MAX_VLAN; i++) begin
			if (i < int'(p.vlan_count)) begin
				if (tag_id_invalid_mask[i*NUM_TYPES + int'(p.vlan_type[i])]) tags_valid = 1'b0;
				if (vlan_accept_filter_cfg[2*i +: 2] == FLT_WITHOUT) vlan_reject = 1'b1;
			end else begin
				if (vlan_accept_filter_cfg[2*i +: 2] == FLT_WITH) vlan_reject = 1'b1;
			end
		end
	end
	wire logic routable  = !p.non_ip && tags_valid && route_tag_count_mask[p.vlan_count];
	wire logic ext_rej   = (ext_tag_accept_filter_cfg == FLT_WITHOUT && p.ext_present) ||
		(ext_tag_accept_filter_cfg == FLT_WITH && !p.ext_present);
	wire logic ctrl_mac  = in_frame.dmac[47:8] == CTRL_PREFIX && (in_frame.dmac[7:4] == 4'h0 ||
		in_frame.dmac[7:4] == 4'h2 || in_frame.dmac[7:4] == 4'h3);
	wire logic untagged  = p.vlan_count == 2'h0 && !p.ext_present;
	wire logic bypass    = ctrl_mac && untagged;
	wire logic mac_rej   = (ctrl[CTRL_DROP_MC] && in_frame.smac[40]) ||
		(ctrl[CTRL_DROP_NULL] && (in_frame.smac == 48'h0000_0000_0000 || in_frame.dmac == 48'h0000_0000_0000));
	wire logic discard   = active && (mac_rej || (!bypass && (vlan_reject || ext_rej)));

	itp_result_t next_res;
	always_comb begin
		next_res            = p;
		next_res.active     = active;
		next_res.routable   = routable && !discard;
		next_res.discard    = discard;
		next_res.learn_dis  = discard;
		next_res.pipe_point = discard ? PT_CLASSIFIER : pt_in;
	end

	// ==========================================================
	// output stage
	assign in_ready = !out_valid || out_ready;
	wire logic take = in_valid && in_ready;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			out_valid <= 1'b0;
			out_res   <= '0;
		end else begin
			if (take) out_res <= next_res;
			out_valid <= take || (out_valid && !out_ready);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_accept  <= 16'h0000;
			cnt_discard <= 16'h0000;
		end else if (take) begin
			if (discard) cnt_discard <= cnt_discard + 16'h0001;
			else cnt_accept <= cnt_accept + 16'h0001;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_take;
		in_valid && in_ready;
	endsequence
	sequence s_plain_first(logic [15:0] id);
		s_take ##0 (in_frame.hw[0] == id && !ext_tag_parse_en && !red_tag_parse_en);
	endsequence

	a_out_hold_stable: assert property (out_valid && !out_ready |=> out_valid && $stable(out_res))
		else $error("output changed while stalled");
	a_discard_point_set: assert property (out_valid && out_res.discard |->
		out_res.pipe_point == PT_CLASSIFIER && out_res.learn_dis && !out_res.routable)
		else $error("discarded frame without classifier point");
	a_ctag_first_seen: assert property (s_plain_first(TPID_CTAG) |=>
		out_valid && out_res.vlan_count != 2'h0 && out_res.vlan_type[0] == 3'h0)
		else $error("customer tag not recognised");
	a_stag_first_seen: assert property (s_plain_first(TPID_STAG) |=>
		out_res.vlan_count != 2'h0 && out_res.vlan_type[0] == 3'h1)
		else $error("service tag not recognised");
	a_ext_off_untagged: assert property (s_plain_first(TPID_EXT) |=>
		out_res.vlan_count == 2'h0 && !out_res.ext_present && !out_res.tag_info_available)
		else $error("extension tag parsed while disabled");
	a_flag_from_tags: assert property (out_valid |->
		out_res.tag_info_available == (out_res.ext_present || out_res.red_present))
		else $error("tag info flag mismatch");
	a_red_slot_count: assert property (out_valid && out_res.red_present |-> out_res.vlan_count <= 2'h2)
		else $error("redundancy tag did not take a slot");
	a_route_count_ok: assert property (out_valid && out_res.routable |->
		route_tag_count_mask[out_res.vlan_count] && !out_res.non_ip)
		else $error("routable with disabled tag count");
	a_mc_smac_drop: assert property (s_take ##0 (active && ctrl[CTRL_DROP_MC] && in_frame.smac[40]) |=>
		out_valid && out_res.discard && out_res.learn_dis)
		else $error("multicast source mac not dropped");
	a_loop_sat_map: assert property (s_take ##0 (in_frame.pipe_action == ACT_LOOPBACK &&
		in_frame.pipe_point == PT_RW_SATELLITE) |=> out_res.pipe_point == PT_LOOKUP && !out_res.active)
		else $error("satellite point not mapped to lookup");
	a_ext_tag_seen: assert property (s_take ##0 (ext_tag_parse_en && !red_tag_parse_en && in_frame.hw[0] == TPID_EXT)
		|=> out_res.ext_present && out_res.tag_info_available && out_res.ext_tag[47:32] == $past(in_frame.hw[1]))
		else $error("extension tag not parsed while enabled");
	a_red_seq_copy: assert property (s_take ##0 (red_tag_parse_en && !ext_tag_parse_en && in_frame.hw[0] == TPID_RED)
		|=> out_res.red_present && out_res.red_sequence_number == $past(in_frame.hw[2]))
		else $error("redundancy sequence number not copied");
	a_vlan_limit_nonip: assert property (s_take ##0 (in_frame.hw[0] == TPID_CTAG && in_frame.hw[2] == TPID_CTAG &&
		in_frame.hw[4] == TPID_CTAG && in_frame.hw[6] == TPID_CTAG) |=> out_res.non_ip && !out_res.routable)
		else $error("four vlan tags not marked non-ip");
	a_ext_twice_nonip: assert property (s_take ##0 (ext_tag_parse_en && !red_tag_parse_en &&
		in_frame.hw[0] == TPID_EXT && in_frame.hw[4] == TPID_EXT) |=> out_res.non_ip)
		else $error("second extension tag not marked non-ip");
endmodule : itp_parser_filter
`default_nettype wire

// [verif/itp_sink_model.sv]
// downstream stage model taking classification results, with optional stalls
`timescale 1ns/10ps
`default_nettype none
module itp_sink_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// stall control
	input  wire logic stall_en,
	// result handshake
	output logic      out_ready
);
	// ==========================================================
	// ready on about half the cycles while stalling
	always_ff @(posedge clk) begin
		if (!resetn)
			out_ready <= 1'b0;
		else
			out_ready <= !stall_en || ($urandom % 2 == 0);
	end
endmodule : itp_sink_model
`default_nettype wire

// [verif/test_ingress_tag_parser_filter.sv]
// self-checking bench of the ingress tag parser and filter
`timescale 1ns/10ps
`default_nettype none
module test_ingress_tag_parser_filter import itp_pkg::*;;
	// ==========================================================
	// compare masks over the packed result summary
	localparam logic [47:0] MB = 48'h0000_ff00_ffff;
	localparam logic [47:0] MN = 48'h0000_c700_0000;
	localparam logic [47:0] MD = 48'h0000_fff0_ffff;
	localparam logic [47:0] MS = 48'hffff_ff00_ffff;
	localparam logic [47:0] MP = 48'h0000_80f0_0000;
	localparam logic [47:0] PD = 48'h0000_0010_0000;
	localparam logic [3:0]  PI[10] = '{PT_RW_PORT_MAINT, PT_RW_OUTER_MAINT, PT_RW_INNER_MAINT, PT_RW_SATELLITE,
		PT_RW_OUTER_SW, PT_RW_INNER_SW, PT_CLASSIFIER, PT_LOOKUP, PT_CLASSIFIER, PT_LOOKUP};
	localparam logic [3:0]  PO[10] = '{PT_PORT_MAINT, PT_OUTER_MAINT, PT_INNER_MAINT, PT_LOOKUP,
		PT_OUTER_SW, PT_INNER_SW, PT_CLASSIFIER, PT_LOOKUP, PT_CLASSIFIER, PT_LOOKUP};
	localparam logic [9:0]  AV = 10'b1101000000;
	logic        clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack, in_valid, in_ready, out_valid, out_ready, stall_en;
	logic [7:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r, q;
	itp_frame_t  in_frame;
	itp_result_t out_res;
	logic [47:0] eq[$], mq[$], dm, sm;
	logic [15:0] h[$], sq;
	logic [1:0]  ac;
	logic [3:0]  pp;
	int          num_errors, samples_checked, cyc_cnt, i, nf, nd;

	itp_parser_filter dut_u (.clk(clk), .resetn(resetn), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
		.wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
		.in_valid(in_valid), .in_ready(in_ready), .in_frame(in_frame), .out_valid(out_valid),
		.out_ready(out_ready), .out_res(out_res));
	itp_sink_model sink_u (.clk(clk), .resetn(resetn), .stall_en(stall_en), .out_ready(out_ready));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ==========================================================
	// helpers
	function automatic logic [47:0] ex(input logic ni, ta, input logic [1:0] vc, input logic rt, ds,
		input logic [15:0] et);
		return {16'h0, 1'b1, ni, ta, vc, rt, ds, ds, 8'h0, et};
	endfunction : ex
	function automatic logic [47:0] pick(input itp_result_t r);
		return {r.red_sequence_number, r.active, r.non_ip, r.tag_info_available, r.vlan_count, r.routable,
			r.discard, r.learn_dis, r.pipe_point, 4'h0, r.ethertype};
	endfunction : pick
	task automatic chk(input logic [47:0] got, exp, msk);
		samples_checked++;
		if (((got ^ exp) & msk) !== 48'h0) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat_w <= d;
		do begin
			@(posedge clk);
		end while (wb_ack !== 1'b1);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk({16'h0, q}, {16'h0, e}, 48'h0000_ffff_ffff);
	endtask : rd
	task automatic cfg(input logic [31:0] c, v, f);
		wb(1'b1, ADR_CTRL, c);
		wb(1'b1, ADR_VALID, v);
		wb(1'b1, ADR_FILT, f);
	endtask : cfg
	// tag identifier then random body halfwords
	task automatic tg(input logic [15:0] id);
		int k;
		h.push_back(id);
		for (k = 0; k < ((id == TPID_EXT) ? 3 : (id == TPID_RED) ? 2 : 1); k++)
			h.push_back(16'($urandom));
		sq = h[$];
	endtask : tg
	task automatic go(input logic [15:0] et, input logic [47:0] e, m);
		itp_frame_t f;
		int n;
		h.push_back(et);
		f = '0;
		f.dmac = dm;
		f.smac = sm;
		f.pipe_action = ac;
		f.pipe_point = pp;
		for (n = 0; n < h.size(); n++)
			f.hw[n] = h[n];
		h.delete();
		eq.push_back(e);
		mq.push_back(m);
		nf++;
		nd += int'(e[25]);
		in_frame <= f;
		in_valid <= 1'b1;
		do begin
			@(posedge clk);
		end while (in_ready !== 1'b1);
	endtask : go
	task automatic fin;
		in_valid <= 1'b0;
		do begin
			@(posedge clk);
		end while (eq.size() != 0);
	endtask : fin
	task print_verdict;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	// ==========================================================
	// result watcher and hang guard
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			num_errors++;
			$display("MISMATCH %0t timeout", $time);
			print_verdict;
		end else if (resetn === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (eq.size() == 0) begin
				num_errors++;
				$display("MISMATCH %0t unexpected result", $time);
			end else
				chk(pick(out_res), eq.pop_front(), mq.pop_front());
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		{resetn, wb_cyc, wb_stb, wb_we, in_valid, stall_en, wb_adr, wb_dat_w} = '0;
		wb_sel = 4'hf;
		in_frame = '0;
		{num_errors, samples_checked, cyc_cnt, nf, nd} = '0;
		dm = 48'h0000_1111_2222;
		sm = 48'h0000_3333_4444;
		ac = ACT_NONE;
		pp = PT_NONE;
		void'($urandom(32'hb20a76a9));
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rd(ADR_CTRL, RST_CTRL);
		rd(ADR_VALID, RST_VALID);
		rd(ADR_FILT, RST_FILT);
		rd(ADR_CUSTOM2, {16'h0, RST_CUSTOM});
		rd(8'h40, 32'h0);
		wb(1'b1, ADR_VALID, 32'hffff_ffff);
		rd(ADR_VALID, 32'h000f_7fff);
		wb(1'b1, ADR_STAT, 32'hffff_ffff);
		rd(ADR_STAT, 32'h0);
		wb_sel <= 4'h1;
		wb(1'b1, ADR_CUSTOM0, 32'hffff_1234);
		wb_sel <= 4'hf;
		rd(ADR_CUSTOM0, 32'h0000_0034);
		for (i = 0; i < 3; i++)
			wb(1'b1, ADR_CUSTOM0 + 8'(4 * i), 32'h9100 + 32'(i * 'h100));
		stall_en <= 1'b1;
		cfg(32'h0, 32'h000f_0002, 32'h0);
		go(16'h0800, ex(0, 0, 0, 1, 0, 16'h0800), MB);
		tg(TPID_CTAG); go(16'h0800, ex(0, 0, 1, 1, 0, 16'h0800), MB);
		tg(TPID_STAG); go(16'h0800, ex(0, 0, 1, 0, 0, 16'h0800), MB);
		tg(16'h9100); tg(TPID_CTAG); go(16'h86dd, ex(0, 0, 2, 1, 0, 16'h86dd), MB);
		tg(16'h9200); tg(16'h9300); tg(TPID_CTAG); go(16'h0800, ex(0, 0, 3, 1, 0, 16'h0800), MB);
		for (i = 0; i < 4; i++)
			tg(TPID_CTAG);
		go(16'h0800, ex(1, 0, 0, 0, 0, 16'h0), MN);
		tg(TPID_EXT); tg(TPID_CTAG); go(16'h0800, ex(0, 0, 0, 1, 0, TPID_EXT), MB);
		tg(TPID_RED); tg(TPID_CTAG); go(16'h0800, ex(0, 0, 0, 1, 0, TPID_RED), MB);
		fin;
		cfg(32'h0, 32'h0002_7ffe, 32'h0);
		go(16'h0800, ex(0, 0, 0, 0, 0, 16'h0800), MB);
		tg(TPID_CTAG); go(16'h0800, ex(0, 0, 1, 1, 0, 16'h0800), MB);
		tg(TPID_STAG); go(16'h0800, ex(0, 0, 1, 0, 0, 16'h0800), MB);
		tg(TPID_CTAG); tg(TPID_CTAG); go(16'h0800, ex(0, 0, 2, 0, 0, 16'h0800), MB);
		fin;
		cfg(32'h1, 32'h000f_0000, 32'h0);
		tg(TPID_EXT); tg(TPID_CTAG); go(16'h0800, ex(0, 1, 1, 1, 0, 16'h0800), MB);
		tg(TPID_EXT);
		for (i = 0; i < 3; i++)
			tg(TPID_CTAG);
		go(16'h0800, ex(0, 1, 3, 1, 0, 16'h0800), MB);
		tg(TPID_EXT); tg(TPID_EXT); go(16'h0800, ex(1, 0, 0, 0, 0, 16'h0), MN);
		tg(TPID_CTAG); tg(TPID_EXT); go(16'h0800, ex(0, 0, 1, 1, 0, TPID_EXT), MB);
		fin;
		cfg(32'h2, 32'h0004_7fde, 32'h0);
		tg(TPID_RED); tg(TPID_CTAG); tg(TPID_CTAG);
		go(16'h0800, ex(0, 1, 2, 1, 0, 16'h0800) | {h[2], 32'h0}, MS);
		tg(TPID_CTAG); tg(TPID_RED); tg(TPID_CTAG);
		go(16'h0800, ex(0, 1, 2, 1, 0, 16'h0800) | {h[4], 32'h0}, MS);
		tg(TPID_CTAG); tg(TPID_CTAG); tg(TPID_RED);
		go(16'h0800, ex(0, 1, 2, 1, 0, 16'h0800) | {sq, 32'h0}, MS);
		tg(TPID_RED); go(16'h0800, ex(0, 1, 0, 0, 0, 16'h0800) | {sq, 32'h0}, MS);
		tg(TPID_RED); tg(TPID_RED); go(16'h0800, ex(1, 0, 0, 0, 0, 16'h0), MN);
		tg(TPID_CTAG); tg(TPID_CTAG); tg(TPID_CTAG); tg(TPID_RED);
		go(16'h0800, ex(1, 0, 0, 0, 0, 16'h0), MN);
		fin;
		cfg(32'hc, 32'h000f_0000, 32'h2);
		go(16'h0800, ex(0, 0, 0, 0, 1, 16'h0800) | PD, MD);
		tg(TPID_CTAG); go(16'h0800, ex(0, 0, 1, 1, 0, 16'h0800), MB);
		dm = 48'h0180_c200_0021;
		go(16'h0800, ex(0, 0, 0, 1, 0, 16'h0800), MB);
		dm = 48'h0180_c200_0010;
		go(16'h0800, ex(0, 0, 0, 0, 1, 16'h0800) | PD, MD);
		dm = 48'h0;
		tg(TPID_CTAG); go(16'h0800, ex(0, 0, 1, 0, 1, 16'h0800) | PD, MD);
		dm = 48'h0000_1111_2222;
		sm = 48'h0100_0000_0001;
		tg(TPID_CTAG); go(16'h0800, ex(0, 0, 1, 0, 1, 16'h0800) | PD, MD);
		sm = 48'h0;
		tg(TPID_CTAG); go(16'h0800, ex(0, 0, 1, 0, 1, 16'h0800) | PD, MD);
		sm = 48'h0000_3333_4444;
		fin;
		cfg(32'h0, 32'h000f_0000, 32'h1);
		tg(TPID_CTAG); go(16'h0800, ex(0, 0, 1, 0, 1, 16'h0800) | PD, MD);
		go(16'h0800, ex(0, 0, 0, 1, 0, 16'h0800), MB);
		fin;
		cfg(32'h1, 32'h000f_0000, 32'h200);
		tg(TPID_EXT); tg(TPID_CTAG); go(16'h0800, ex(0, 1, 1, 1, 0, 16'h0800), MB);
		tg(TPID_CTAG); go(16'h0800, ex(0, 0, 1, 0, 1, 16'h0800) | PD, MD);
		fin;
		wb(1'b1, ADR_FILT, 32'h100);
		tg(TPID_EXT); tg(TPID_CTAG); go(16'h0800, ex(0, 1, 1, 0, 1, 16'h0800) | PD, MD);
		go(16'h0800, ex(0, 0, 0, 1, 0, 16'h0800), MB);
		fin;
		cfg(32'h0, 32'h000f_0000, 32'h0);
		for (i = 0; i < 10; i++) begin
			ac = (i < 6) ? ACT_LOOPBACK : (i < 8) ? ACT_INJECT : ACT_EXTRACT;
			pp = PI[i];
			go(16'h0800, {16'h0, AV[i], 7'h0, PO[i], 20'h0}, MP);
		end
		fin;
		rd(ADR_STAT, {16'(nd), 16'(nf - nd)});
		print_verdict;
	end
endmodule : test_ingress_tag_parser_filter
`default_nettype wire
